/* File: nand_host_pkg.sv */
package nand_host_pkg;
    // nand commands
    localparam logic [7:0] cmd_reset = 8'hff;
    localparam logic [7:0] cmd_status = 8'h70;
    localparam logic [7:0] cmd_status_plane = 8'h78;
    localparam logic [7:0] cmd_read_id = 8'h90;
    localparam logic [7:0] cmd_dummy = 8'h00;
    localparam logic [7:0] addr_id = 8'h00;
    // status byte fields
    localparam int st_fail_bit = 0;
    localparam int st_otp_bit = 3;
    localparam int st_ecc_bit = 4;
    localparam int st_array_rdy_bit = 5;
    localparam int st_ready_bit = 6;
    localparam int st_wp_n_bit = 7;
    localparam logic [7:0] st_after_reset_wp_hi = 8'he0;
    localparam logic [7:0] st_after_reset_wp_lo = 8'h60;
    // id byte fields
    localparam int id_max_bytes = 5;
    localparam logic [2:0] id_cnt_max = 3'h5;
    // axi register map (byte addresses)
    localparam logic [7:0] reg_control = 8'h00;
    localparam logic [7:0] reg_status = 8'h04;
    localparam logic [7:0] reg_id_lo = 8'h08;
    localparam logic [7:0] reg_id_hi = 8'h0c;
    localparam logic [7:0] reg_op_status = 8'h10;
    // control register bits (bits 0 to 2 write 1 to start; bit 3 selects a five-byte id read)
    localparam int ctl_reset_bit = 0;
    localparam int ctl_read_id_bit = 1;
    localparam int ctl_read_status_bit = 2;
    localparam int ctl_id_len5_bit = 3;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;
    // pin timing at 10 MHz: one cycle covers each strobe phase
    localparam int clk_period_ns = 100;
    localparam int strobe_min_ns = 25;
    localparam int strobe_cycles = (strobe_min_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [3:0] strobe_cnt = 4'(strobe_cycles);
    typedef enum logic [1:0] {op_none_type_v, op_cmd_type_v, op_addr_type_v, op_read_type_v} pin_op_type;
endpackage : nand_host_pkg

/* File: nand_pin_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface nand_pin_if;
    import nand_host_pkg::*;
    logic start;
    pin_op_type op;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport master (output start, output op, output wdata, input done, input rdata);
    modport sequencer (input start, input op, input wdata, output done, output rdata);
endinterface : nand_pin_if
`default_nettype wire

/* File: nand_pin_cycle.sv */
`timescale 1ns/1ns
`default_nettype none
// one command, address or read cycle on the multiplexed bus
module nand_pin_cycle
    import nand_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    nand_pin_if.sequencer cyc,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in
);
    typedef enum logic [1:0] {ph_idle, ph_low, ph_high} phase_type;
    phase_type ph_q, ph_d;
    logic [3:0] cnt_q, cnt_d;
    logic cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d, oe_q, oe_d, done_q, done_d;
    logic [7:0] out_q, out_d, rd_q, rd_d;
    pin_op_type op_q, op_d;

    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        cle_d = cle_q;
        ale_d = ale_q;
        we_n_d = we_n_q;
        re_n_d = re_n_q;
        oe_d = oe_q;
        out_d = out_q;
        rd_d = rd_q;
        op_d = op_q;
        done_d = 1'b0;
        case (ph_q)
            ph_idle: begin
                if (cyc.start) begin
                    op_d = cyc.op;
                    cle_d = (cyc.op == op_cmd_type_v);
                    ale_d = (cyc.op == op_addr_type_v);
                    oe_d = (cyc.op != op_read_type_v);
                    out_d = cyc.wdata;
                    we_n_d = (cyc.op == op_read_type_v);
                    re_n_d = (cyc.op != op_read_type_v);
                    cnt_d = strobe_cnt;
                    ph_d = ph_low;
                end
            end
            ph_low: begin
                if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    // data sampled just before re rises; rd_q holds it until the next read cycle
                    if (op_q == op_read_type_v) begin
                        rd_d = io_in;
                    end
                    we_n_d = 1'b1;
                    re_n_d = 1'b1;
                    cnt_d = strobe_cnt;
                    ph_d = ph_high;
                end
            end
            default: begin
                if (cnt_q > 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    cle_d = 1'b0;
                    ale_d = 1'b0;
                    oe_d = 1'b0;
                    done_d = 1'b1;
                    ph_d = ph_idle;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ph_q <= ph_idle;
            cnt_q <= 4'h0;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            oe_q <= 1'b0;
            out_q <= 8'h00;
            rd_q <= 8'h00;
            op_q <= op_none_type_v;
            done_q <= 1'b0;
        end else if (clk_en) begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            cle_q <= cle_d;
            ale_q <= ale_d;
            we_n_q <= we_n_d;
            re_n_q <= re_n_d;
            oe_q <= oe_d;
            out_q <= out_d;
            rd_q <= rd_d;
            op_q <= op_d;
            done_q <= done_d;
        end
    end

    assign cle = cle_q;
    assign ale = ale_q;
    assign we_n = we_n_q;
    assign re_n = re_n_q;
    assign io_out = out_q;
    assign io_oe = oe_q;
    assign cyc.done = done_q;
    assign cyc.rdata = rd_q;
endmodule : nand_pin_cycle
`default_nettype wire

/* File: nand_status_host.sv */
`timescale 1ns/1ns
`default_nettype none
module nand_status_host
    import nand_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_we_n,
    output logic read_strobe_pin_n,
    output logic [7:0] nand_io_out,
    output logic nand_io_oe,
    input wire logic [7:0] nand_io_in,
    input wire logic nand_ready
);
    typedef enum logic [3:0] {
        st_boot, st_idle, st_issue, st_wait_cyc, st_wait_busy, st_id_read, st_stat_read
    } seq_type;
    typedef enum logic [1:0] {job_reset, job_id, job_status} job_type;

    nand_pin_if cyc ();
    logic p_cle, p_ale, p_we_n, p_re_n, p_oe;
    logic [7:0] p_out;

    nand_pin_cycle u_pin (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .cyc(cyc),
        .cle(p_cle),
        .ale(p_ale),
        .we_n(p_we_n),
        .re_n(p_re_n),
        .io_out(p_out),
        .io_oe(p_oe),
        .io_in(nand_io_in)
    );

    seq_type st_q, st_d;
    job_type job_q, job_d;
    logic [2:0] step_q, step_d;
    logic [2:0] idx_q, idx_d;
    logic start_q, start_d;
    pin_op_type op_q, op_d;
    logic [7:0] wd_q, wd_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] id_q [id_max_bytes];
    logic [7:0] id_d [id_max_bytes];
    logic id_len5_q, id_len5_d, in_id_q, in_id_d, reset_done_q, reset_done_d, err_q, err_d;
    logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] aw_q, aw_d;
    logic [31:0] w_q, w_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == reg_control) || (a == reg_status) || (a == reg_id_lo) || (a == reg_id_hi) ||
            (a == reg_op_status);
    endfunction : addr_ok

    function automatic logic busy_f(input seq_type s);
        busy_f = (s != st_idle);
    endfunction : busy_f

    assign cyc.start = start_q;
    assign cyc.op = op_q;
    assign cyc.wdata = wd_q;

    always_comb begin
        st_d = st_q;
        job_d = job_q;
        step_d = step_q;
        idx_d = idx_q;
        start_d = 1'b0;
        op_d = op_q;
        wd_d = wd_q;
        stat_d = stat_q;
        id_d = id_q;
        id_len5_d = id_len5_q;
        in_id_d = in_id_q;
        reset_done_d = reset_done_q;
        err_d = err_q;
        awr_d = 1'b0;
        wr_d = 1'b0;
        bv_d = bv_q;
        bresp_d = bresp_q;
        arr_d = 1'b0;
        rv_d = rv_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        aw_d = aw_q;
        w_d = w_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        // write channels, taken independently
        if (s_axi_awvalid && awr_q) begin
            aw_d = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && wr_q) begin
            w_d = s_axi_wdata;
            w_have_d = 1'b1;
        end
        awr_d = !aw_have_d && !bv_q;
        wr_d = !w_have_d && !bv_q;
        if (s_axi_bvalid && s_axi_bready) begin
            bv_d = 1'b0;
        end
        // command sequencer; first job after power-on is always reset
        case (st_q)
            st_boot: begin
                job_d = job_reset;
                step_d = 3'h0;
                st_d = st_issue;
            end
            st_idle: begin
                if (aw_have_q && w_have_q && !bv_q) begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bv_d = 1'b1;
                    bresp_d = addr_ok(aw_q) ? axi_okay : axi_slverr;
                    if (aw_q == reg_control && s_axi_wstrb[0]) begin
                        step_d = 3'h0;
                        id_len5_d = w_q[ctl_id_len5_bit];
                        if (w_q[ctl_reset_bit]) begin
                            job_d = job_reset;
                            st_d = st_issue;
                        end else if (w_q[ctl_read_id_bit]) begin
                            job_d = job_id;
                            idx_d = 3'h0;
                            st_d = st_issue;
                        end else if (w_q[ctl_read_status_bit]) begin
                            job_d = job_status;
                            st_d = st_issue;
                        end
                    end
                end
            end
            st_issue: begin
                start_d = 1'b1;
                st_d = st_wait_cyc;
                case (job_q)
                    job_reset: begin
                        op_d = op_cmd_type_v;
                        wd_d = cmd_reset;
                    end
                    job_id: begin
                        op_d = (step_q == 3'h0) ? op_cmd_type_v : op_addr_type_v;
                        wd_d = (step_q == 3'h0) ? cmd_read_id : addr_id;
                    end
                    default: begin
                        // leaving id mode needs a dummy command before 70h
                        op_d = op_cmd_type_v;
                        wd_d = (step_q == 3'h0 && in_id_q) ? cmd_dummy : cmd_status;
                    end
                endcase
            end
            st_wait_cyc: begin
                if (cyc.done) begin
                    case (job_q)
                        job_reset: st_d = st_wait_busy;
                        job_id: begin
                            if (step_q == 3'h0) begin
                                step_d = 3'h1;
                                st_d = st_issue;
                            end else begin
                                in_id_d = 1'b1;
                                st_d = st_id_read;
                            end
                        end
                        default: begin
                            if (step_q == 3'h0 && in_id_q) begin
                                step_d = 3'h1;
                                in_id_d = 1'b0;
                                st_d = st_issue;
                            end else begin
                                st_d = st_stat_read;
                            end
                        end
                    endcase
                end
            end
            st_wait_busy: begin
                // ready/busy returning high ends the reset interval
                if (nand_ready) begin
                    in_id_d = 1'b0;
                    reset_done_d = 1'b1;
                    job_d = job_status;
                    step_d = 3'h0;
                    st_d = st_issue;
                end
            end
            st_id_read: begin
                if (!start_q && !cyc.done && idx_q == 3'h0 && step_q == 3'h1) begin
                    op_d = op_read_type_v;
                    start_d = 1'b1;
                    step_d = 3'h2;
                end else if (cyc.done) begin
                    id_d[idx_q] = cyc.rdata;
                    if (idx_q + 3'h1 < (id_len5_q ? id_cnt_max : id_cnt_max - 3'h1)) begin
                        idx_d = idx_q + 3'h1;
                        op_d = op_read_type_v;
                        start_d = 1'b1;
                    end else begin
                        st_d = st_idle;
                    end
                end
            end
            default: begin
                if (step_q != 3'h7 && !start_q) begin
                    op_d = op_read_type_v;
                    start_d = 1'b1;
                    step_d = 3'h7;
                end else if (cyc.done) begin
                    // no set-feature is ever sent, so bit 4 keeps its default rewrite-advice meaning
                    stat_d = cyc.rdata;
                    // fail bit meaningless until a program or erase has run
                    err_d = cyc.rdata[st_fail_bit];
                    st_d = st_idle;
                end
            end
        endcase
        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (s_axi_arvalid && arr_q) begin
            rv_d = 1'b1;
            rresp_d = addr_ok(s_axi_araddr) ? axi_okay : axi_slverr;
            if (s_axi_araddr == reg_status) begin
                rdata_d = {28'h0, err_q, reset_done_q, in_id_q, busy_f(st_q)};
            end else if (s_axi_araddr == reg_id_lo) begin
                rdata_d = {id_q[3], id_q[2], id_q[1], id_q[0]};
            end else if (s_axi_araddr == reg_id_hi) begin
                rdata_d = {24'h0, id_q[4]};
            end else if (s_axi_araddr == reg_op_status) begin
                rdata_d = {24'h0, stat_q};
            end else if (s_axi_araddr == reg_control) begin
                rdata_d = {28'h0, id_len5_q, 3'h0};
            end else begin
                rdata_d = 32'h0;
            end
        end
        arr_d = !rv_d && !arr_q;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= st_boot;
            job_q <= job_reset;
            step_q <= 3'h0;
            idx_q <= 3'h0;
            start_q <= 1'b0;
            op_q <= op_none_type_v;
            wd_q <= 8'h00;
            stat_q <= 8'h00;
            for (int i = 0; i < id_max_bytes; i++) begin
                id_q[i] <= 8'h00;
            end
            id_len5_q <= 1'b0;
            in_id_q <= 1'b0;
            reset_done_q <= 1'b0;
            err_q <= 1'b0;
            awr_q <= 1'b0;
            wr_q <= 1'b0;
            bv_q <= 1'b0;
            bresp_q <= axi_okay;
            arr_q <= 1'b0;
            rv_q <= 1'b0;
            rresp_q <= axi_okay;
            rdata_q <= 32'h0;
            aw_q <= 8'h00;
            w_q <= 32'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            job_q <= job_d;
            step_q <= step_d;
            idx_q <= idx_d;
            start_q <= start_d;
            op_q <= op_d;
            wd_q <= wd_d;
            stat_q <= stat_d;
            id_q <= id_d;
            id_len5_q <= id_len5_d;
            in_id_q <= in_id_d;
            reset_done_q <= reset_done_d;
            err_q <= err_d;
            awr_q <= awr_d;
            wr_q <= wr_d;
            bv_q <= bv_d;
            bresp_q <= bresp_d;
            arr_q <= arr_d;
            rv_q <= rv_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            aw_q <= aw_d;
            w_q <= w_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign nand_cle = p_cle;
    assign nand_ale = p_ale;
    assign nand_we_n = p_we_n;
    assign read_strobe_pin_n = p_re_n;
    assign nand_io_out = p_out;
    assign nand_io_oe = p_oe;
endmodule : nand_status_host
`default_nettype wire

/* File: nand_status_host_props.sv */
`timescale 1ns/1ns
`default_nettype none
module nand_status_host_props
    import nand_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic nand_cle,
    input wire logic nand_ale,
    input wire logic nand_we_n,
    input wire logic read_strobe_pin_n,
    input wire logic [7:0] nand_io_out,
    input wire logic nand_io_oe
);
    logic cmd_stb;
    logic seen_q, seen_d, idm_q, idm_d;
    assign cmd_stb = nand_cle && !nand_we_n;
    // idm tracks whether the last command written was the id entry
    always_comb begin
        seen_d = seen_q | cmd_stb;
        idm_d = idm_q;
        if (cmd_stb) idm_d = (nand_io_out == cmd_read_id);
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen_q <= 1'b0;
            idm_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
            idm_q <= idm_d;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence cmd_s(logic [7:0] c);
        cmd_stb && nand_io_out == c;
    endsequence
    sequence addr_zero_s;
        nand_ale && !nand_we_n && nand_io_out == addr_id;
    endsequence
    a_first_cmd_reset: assert property (cmd_stb && !seen_q |-> nand_io_out == cmd_reset)
        else $error("first command is not reset");
    a_id_addr_zero: assert property (cmd_s(cmd_read_id) |-> ##[1:20] addr_zero_s)
        else $error("id command not followed by address zero");
    a_dummy_first: assert property (cmd_s(cmd_status) |-> !idm_q)
        else $error("status command sent straight after id");
    a_status_read: assert property (cmd_s(cmd_status) |-> !nand_ale throughout (##[1:40] !read_strobe_pin_n))
        else $error("status command not followed by a read cycle");
    a_read_released: assert property ($fell(read_strobe_pin_n) |-> !nand_io_oe && !nand_cle && !nand_ale)
        else $error("bus driven during read cycle");
endmodule : nand_status_host_props
bind nand_status_host nand_status_host_props i_props (
    .sys_clk(sys_clk), .srst(srst), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
    .read_strobe_pin_n(read_strobe_pin_n), .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe));
`default_nettype wire

/* File: nand_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
// clockless device: reacts to strobe edges only
module nand_flash_model #(
    parameter int t_rst_ns = 2000,
    // id bytes are arbitrary values, byte 0 lowest
    parameter logic [39:0] id_bytes = 40'h14_11_00_3c_5a
) (
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [7:0] din,
    input wire logic wp_n,
    output logic [7:0] dout,
    output logic ready
);
    logic [1:0] mode;
    logic [2:0] ptr;
    logic armed;
    logic [7:0] last;
    logic [7:0] cur;
    event rst_ev;
    initial begin
        ready = 1'b1;
        mode = 2'd0;
        ptr = 3'd0;
        armed = 1'b0;
        last = 8'h00;
    end
    // a reset arriving in the busy interval is missed here, so it is ignored
    always @(rst_ev) begin
        ready = 1'b0;
        mode = 2'd0;
        #(t_rst_ns);
        ready = 1'b1;
    end
    always @(posedge we_n) begin
        if (cle) begin
            armed = (din == 8'h90);
            if (din == 8'hff) ->rst_ev;
            else if (din == 8'h00) mode = 2'd0;
            else if ((din == 8'h70 || din == 8'h78) && mode != 2'd2) mode = 2'd1;
        end else if (ale) begin
            if (armed && din == 8'h00) begin
                mode = 2'd2;
                ptr = 3'd0;
            end
            armed = 1'b0;
        end
    end
    // released bus shows the inverse of the last byte
    always @* begin
        cur = ~last;
        if (mode == 2'd1) cur = {wp_n, ready, ready, 5'h00};
        if (mode == 2'd2) cur = id_bytes[ptr * 8 +: 8];
        dout = re_n ? ~last : cur;
    end
    always @(posedge re_n) begin
        last = cur;
        if (mode == 2'd2) ptr = ptr + 3'd1;
    end
endmodule : nand_flash_model
`default_nettype wire

/* File: test_nand_status_host.sv */
`timescale 1ns/1ns
`default_nettype none
module test_nand_status_host;
    import nand_host_pkg::*;
    // id values are arbitrary
    localparam logic [39:0] id_bytes = 40'h14_11_00_3c_5a;
    logic sys_clk, srst, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nand_cle, nand_ale;
    logic nand_we_n, read_strobe_pin_n, nand_io_oe, nand_ready, wp_n, w;
    logic [7:0] s_axi_awaddr, s_axi_araddr, nand_io_out, nand_io_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    typedef struct {logic chk; logic [33:0] exp;} note_type;
    note_type rq[$];
    note_type n;
    logic [1:0] bq[$];
    int n_errors = 0;
    int checks = 0;
    int i;
    nand_status_host i_dut (.*);
    nand_flash_model #(.id_bytes(id_bytes)) i_flash (.cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
        .re_n(read_strobe_pin_n), .din(nand_io_out), .wp_n(wp_n), .dout(nand_io_in), .ready(nand_ready));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task compare_read(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_read
    task compare_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_resp
    task wrap_up;
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // results are compared as they leave the bus, against the oldest note
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            n = rq.pop_front();
            if (n.chk) compare_read({s_axi_rresp, s_axi_rdata}, n.exp);
        end
        if (s_axi_bvalid && s_axi_bready) compare_resp(s_axi_bresp, bq.pop_front());
    end
    task wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
        logic bd;
        begin
            bq.push_back(er);
            bd = 1'b0;
            @(posedge sys_clk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= dat;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!bd) begin
                @(posedge sys_clk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                bd = s_axi_bvalid;
            end
            s_axi_bready <= 1'b0;
        end
    endtask : wr
    task rd(input logic [7:0] a, input logic chk, input logic [33:0] exp, output logic [31:0] q);
        logic rdn;
        begin
            rq.push_back('{chk, exp});
            rdn = 1'b0;
            @(posedge sys_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!rdn) begin
                @(posedge sys_clk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                rdn = s_axi_rvalid;
                q = s_axi_rdata;
            end
            s_axi_rready <= 1'b0;
        end
    endtask : rd
    // a short settle lets the busy flag rise before polling starts
    task wait_idle;
        logic [31:0] q;
        begin
            repeat (3) @(posedge sys_clk);
            q = 32'h1;
            while (q[0]) rd(reg_status, 1'b0, 34'h0, q);
        end
    endtask : wait_idle
    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        wp_n = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        void'($urandom(60660));
        wait_idle();
        rd(reg_op_status, 1'b1, {axi_okay, 32'he0}, d);
        rd(reg_status, 1'b1, {axi_okay, 32'h4}, d);
        $display("test boot done");
        for (i = 0; i < 2; i++) begin
            wr(reg_control, (i == 0) ? 32'ha : 32'h2, axi_okay);
            wait_idle();
            rd(reg_id_lo, 1'b1, {axi_okay, id_bytes[31:0]}, d);
            if (i == 0) rd(reg_id_hi, 1'b1, {axi_okay, 24'h0, id_bytes[39:32]}, d);
            wr(reg_control, 32'h4, axi_okay);
            wait_idle();
            rd(reg_op_status, 1'b1, {axi_okay, 32'he0}, d);
            $display("test id pass %0d done", i);
        end
        for (i = 0; i < 3; i++) begin
            w = 1'($urandom % 2);
            wp_n <= w;
            wr(reg_control, 32'h1, axi_okay);
            // freeze mid-job; the reset sequence must still complete once the enable returns
            clk_en <= 1'b0;
            repeat (5) @(posedge sys_clk);
            clk_en <= 1'b1;
            wait_idle();
            wr(reg_control, 32'h4, axi_okay);
            wait_idle();
            rd(reg_op_status, 1'b1, {axi_okay, 24'h0, w, 7'h60}, d);
            $display("test reset pass %0d done", i);
        end
        rd(8'h20, 1'b1, {axi_slverr, 32'h0}, d);
        wr(8'h20, $urandom, axi_slverr);
        $display("test unmapped done");
        wrap_up();
    end
    initial begin
        #2000000;
        n_errors++;
        wrap_up();
    end
endmodule : test_nand_status_host
`default_nettype wire
